// >>> qss_summary.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RL1: Bit 2 set on any channel time error.
// RL2: Bit 3 set on any questionable power.
// RL3: Bit 4 follows temperature questionable input.
// RL4: Bit 5 set on any frequency fault.
// RL5: Bit 8 set while instrument is unaligned.
// RL6: Bit 9 set on any limit violation.
// RL7: Bit 10 set on any margin violation.
// RL8: Bit 11 set while not synchronised.
// RL9: Premeasurement deviation beyond threshold means unsynchronised.
// RL10: Bit 12 set on any adjacent-limit fail.
// RL11: Bit 13 set on transducer break.
// RL12: Bit 15 always reads zero.
// RL13: Summary bit ORs the flags of active channels only.
// RL14: Subregister reads return the selected channel.
// RL15: Summary readable as condition or event.
// RL16: Each channel keeps its own limit subregister.
// RL17: Bits 0/1 upper/lower adjacent fail.
// RL18: Bits 2/3 upper/lower first alternate fail.
// RL19: Bits 4/5 upper/lower second alternate fail.
// RL20: Bit 6 ORs alternates 3 to 11.
// RL21: Bit 7 gap cumulative leakage fail.
// RL22: Bit 8 gap leakage fail.
// RL23: Unused bits read zero, ignore inputs.
// RL24: Summary condition recomputed within one cycle.
module qss_summary #(
   parameter int NUM_CHAN = 4,
   parameter int NUM_WIN = 4,
   parameter int LEVEL_W = 16,
   parameter int SYNC_DEV_MAX = 16
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [NUM_CHAN-1:0] chan_active,
   input wire logic [NUM_CHAN-1:0] time_error,
   input wire logic [NUM_CHAN-1:0] power_questionable,
   input wire logic temperature_questionable,
   input wire logic [NUM_CHAN-1:0] frequency_fault,
   input wire logic not_aligned_indicator,
   input wire logic [NUM_CHAN*NUM_WIN-1:0] limit_violation,
   input wire logic [NUM_CHAN*NUM_WIN-1:0] margin_violation,
   input wire logic transducer_break,
   input wire logic premeas_valid,
   input wire logic signed [LEVEL_W-1:0] premeas_level,
   input wire logic signed [LEVEL_W-1:0] expected_level,
   input wire logic [NUM_CHAN*qss_pkg::ACP_RAW_W-1:0] acp_raw_fail,
   input wire logic [$clog2(NUM_CHAN+1)-1:0] sel_chan,
   input wire logic rd_en,
   input wire logic rd_reg,
   input wire logic rd_event,
   output logic [15:0] rd_data_q,
   output logic rd_valid_q,
   output logic [15:0] summary_cond_q,
   output logic sync_lost_q
);

   localparam int CHAN_W = $clog2(NUM_CHAN + 1);
   localparam int DEV_W = LEVEL_W + 1;
   localparam logic [DEV_W-1:0] SYNC_LIMIT = DEV_W'(SYNC_DEV_MAX);

   // Read decode state
   typedef enum logic [1:0] {
      QSS_RD_SUM_COND = 2'b00,
      QSS_RD_SUM_EVT = 2'b01,
      QSS_RD_ACP_COND = 2'b10,
      QSS_RD_ACP_EVT = 2'b11
   } qss_rd_kind_t;

   logic [15:0] summary_d;
   logic [15:0] summary_evt_q;
   logic [15:0] acp_cond [NUM_CHAN];
   logic [15:0] acp_evt [NUM_CHAN];
   logic [NUM_CHAN-1:0] acp_any;
   logic [NUM_CHAN-1:0] acp_evt_clr;
   logic [NUM_CHAN-1:0] limit_chan;
   logic [NUM_CHAN-1:0] margin_chan;
   logic [DEV_W-1:0] premeas_dev;
   logic rd_take;
   logic sel_ok;
   logic sum_evt_clr;
   qss_rd_kind_t rd_kind;
   logic [15:0] rd_data_d;

   // Magnitude of the difference of two signed levels
   function automatic logic [DEV_W-1:0] abs_diff(input logic signed [LEVEL_W-1:0] a,
                                                 input logic signed [LEVEL_W-1:0] b);
      logic signed [DEV_W-1:0] diff;
      diff = DEV_W'(a) - DEV_W'(b);
      abs_diff = diff[DEV_W-1] ? DEV_W'(-diff) : DEV_W'(diff);
   endfunction

   // Any window of a channel flagged
   function automatic logic [NUM_CHAN-1:0] any_window(
      input logic [NUM_CHAN*NUM_WIN-1:0] flags);
      logic [NUM_CHAN-1:0] res;
      res = '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
         res[c] = |flags[c*NUM_WIN +: NUM_WIN];
      end
      any_window = res;
   endfunction

   // Per-channel adjacent power limit subregisters
   generate
      for (genvar g = 0; g < NUM_CHAN; g++) begin : g_acp
         qss_acp_channel u_acp (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ce(ce),
            .raw_fail(acp_raw_fail[g*qss_pkg::ACP_RAW_W +: qss_pkg::ACP_RAW_W]),
            .evt_clr(acp_evt_clr[g]),
            .cond_q(acp_cond[g]),
            .evt_q(acp_evt[g])
         ); // RL16
         assign acp_any[g] = |acp_cond[g][qss_pkg::ACP_LAST_USED_BIT:0];
      end
   endgenerate

   // Window flags folded per channel
   assign limit_chan = any_window(limit_violation);
   assign margin_chan = any_window(margin_violation);

   // Premeasurement deviation from the expected level
   assign premeas_dev = abs_diff(premeas_level, expected_level);

   // Synchronisation tracking, updated on each premeasurement result
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_lost_q <= 1'b0;
      end else if (ce && premeas_valid) begin
         sync_lost_q <= (premeas_dev > SYNC_LIMIT); // RL9
      end
   end

   // Summary condition word from live flags of active channels
   always_comb begin
      summary_d = qss_pkg::REG_RESET; // RL12 RL23
      summary_d[qss_pkg::SUM_TIME_BIT] = |(time_error & chan_active); // RL1 RL13
      summary_d[qss_pkg::SUM_POWER_BIT] = |(power_questionable & chan_active); // RL2 RL13
      summary_d[qss_pkg::SUM_TEMP_BIT] = temperature_questionable; // RL3
      summary_d[qss_pkg::SUM_FREQ_BIT] = |(frequency_fault & chan_active); // RL4 RL13
      summary_d[qss_pkg::SUM_ALIGN_BIT] = not_aligned_indicator; // RL5
      summary_d[qss_pkg::SUM_LIMIT_BIT] = |(limit_chan & chan_active); // RL6 RL13
      summary_d[qss_pkg::SUM_MARGIN_BIT] = |(margin_chan & chan_active); // RL7 RL13
      summary_d[qss_pkg::SUM_SYNC_BIT] = sync_lost_q; // RL8
      summary_d[qss_pkg::SUM_ACP_BIT] = |(acp_any & chan_active); // RL10 RL13
      summary_d[qss_pkg::SUM_TRANSDUCER_BIT] = transducer_break; // RL11
   end

   // Condition view register, refreshed every enabled cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         summary_cond_q <= qss_pkg::REG_RESET;
      end else if (ce) begin
         summary_cond_q <= summary_d; // RL24 RL15
      end
   end

   // Read request decode
   assign rd_take = ce & rd_en;
   assign sel_ok = (sel_chan < CHAN_W'(NUM_CHAN));
   assign rd_kind = qss_rd_kind_t'({rd_reg, rd_event});
   assign sum_evt_clr = rd_take & (rd_kind == QSS_RD_SUM_EVT);

   // Event read of a channel clears only that channel's latch
   always_comb begin
      acp_evt_clr = '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
         acp_evt_clr[c] = rd_take & (rd_kind == QSS_RD_ACP_EVT) &
                          (sel_chan == CHAN_W'(c)); // RL14
      end
   end

   // Summary event view: rising conditions latched, cleared by reading
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         summary_evt_q <= qss_pkg::REG_RESET;
      end else if (ce) begin
         summary_evt_q <= qss_pkg::qss_event_next(summary_evt_q, summary_d,
                                                  summary_cond_q, sum_evt_clr); // RL15
      end
   end

   // Read data mux; the selected channel supplies subregister contents
   always_comb begin
      rd_data_d = qss_pkg::REG_RESET;
      case (rd_kind)
         QSS_RD_SUM_COND: begin
            rd_data_d = summary_cond_q; // RL15
         end
         QSS_RD_SUM_EVT: begin
            rd_data_d = summary_evt_q; // RL15
         end
         QSS_RD_ACP_COND: begin
            for (int c = 0; c < NUM_CHAN; c++) begin
               if (sel_ok && sel_chan == CHAN_W'(c)) begin
                  rd_data_d = acp_cond[c]; // RL14
               end
            end
         end
         QSS_RD_ACP_EVT: begin
            for (int c = 0; c < NUM_CHAN; c++) begin
               if (sel_ok && sel_chan == CHAN_W'(c)) begin
                  rd_data_d = acp_evt[c]; // RL14
               end
            end
         end
         default: begin
            rd_data_d = qss_pkg::REG_RESET;
         end
      endcase
   end

   // Registered read answer, one cycle after the request
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= qss_pkg::REG_RESET;
      end else if (rd_take) begin
         rd_data_q <= rd_data_d;
      end
   end

   // Read valid pulse
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_q <= 1'b0;
      end else if (ce) begin
         rd_valid_q <= rd_en;
      end
   end

endmodule // qss_summary
`default_nettype wire

// >>> qss_pkg.sv
`default_nettype none
// Shared constants for the questionable status summary bank
package qss_pkg;

   // Register width and read-port register selects
   localparam int REG_W = 16;
   localparam logic REG_SEL_SUMMARY = 1'b0;
   localparam logic REG_SEL_ACP = 1'b1;

   // Summary register bit positions
   localparam int SUM_TIME_BIT = 2;
   localparam int SUM_POWER_BIT = 3;
   localparam int SUM_TEMP_BIT = 4;
   localparam int SUM_FREQ_BIT = 5;
   localparam int SUM_ALIGN_BIT = 8;
   localparam int SUM_LIMIT_BIT = 9;
   localparam int SUM_MARGIN_BIT = 10;
   localparam int SUM_SYNC_BIT = 11;
   localparam int SUM_ACP_BIT = 12;
   localparam int SUM_TRANSDUCER_BIT = 13;

   // Adjacent power limit register bit positions
   localparam int ACP_ADJ_UP_BIT = 0;
   localparam int ACP_ADJ_LOW_BIT = 1;
   localparam int ACP_ALT1_UP_BIT = 2;
   localparam int ACP_ALT1_LOW_BIT = 3;
   localparam int ACP_ALT2_UP_BIT = 4;
   localparam int ACP_ALT2_LOW_BIT = 5;
   localparam int ACP_HIGHER_BIT = 6;
   localparam int ACP_GAP_CUM_BIT = 7;
   localparam int ACP_GAP_BIT = 8;
   localparam int ACP_LAST_USED_BIT = 8;

   // Raw per-channel fail vector layout
   localparam int RAW_ADJ_UP = 0;
   localparam int RAW_ADJ_LOW = 1;
   localparam int RAW_ALT1_UP = 2;
   localparam int RAW_ALT1_LOW = 3;
   localparam int RAW_ALT2_UP = 4;
   localparam int RAW_ALT2_LOW = 5;
   localparam int RAW_HIGHER_LSB = 6;
   localparam int RAW_HIGHER_MSB = 23;
   localparam int RAW_GAP_CUM = 24;
   localparam int RAW_GAP = 25;
   localparam int ACP_RAW_W = 26;

   // Reset value of every status register
   localparam logic [15:0] REG_RESET = 16'h0000;

   // Latch rising condition bits; a new occurrence wins over the read clear
   function automatic logic [15:0] qss_event_next(input logic [15:0] evt,
                                                  input logic [15:0] cond_new,
                                                  input logic [15:0] cond_old,
                                                  input logic clr);
      qss_event_next = (clr ? REG_RESET : evt) | (cond_new & ~cond_old);
   endfunction

endpackage
`default_nettype wire

// >>> qss_acp_channel.sv
`timescale 1ns/100ps
`default_nettype none
// One channel's adjacent power limit subregister: condition and event views
module qss_acp_channel (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [qss_pkg::ACP_RAW_W-1:0] raw_fail,
   input wire logic evt_clr,
   output logic [15:0] cond_q,
   output logic [15:0] evt_q
);

   logic [15:0] cond_d;

   // Build condition word from raw fail flags; unused bits stay zero
   always_comb begin
      cond_d = qss_pkg::REG_RESET; // RL12 RL23
      cond_d[qss_pkg::ACP_ADJ_UP_BIT] = raw_fail[qss_pkg::RAW_ADJ_UP]; // RL17
      cond_d[qss_pkg::ACP_ADJ_LOW_BIT] = raw_fail[qss_pkg::RAW_ADJ_LOW]; // RL17
      cond_d[qss_pkg::ACP_ALT1_UP_BIT] = raw_fail[qss_pkg::RAW_ALT1_UP]; // RL18
      cond_d[qss_pkg::ACP_ALT1_LOW_BIT] = raw_fail[qss_pkg::RAW_ALT1_LOW]; // RL18
      cond_d[qss_pkg::ACP_ALT2_UP_BIT] = raw_fail[qss_pkg::RAW_ALT2_UP]; // RL19
      cond_d[qss_pkg::ACP_ALT2_LOW_BIT] = raw_fail[qss_pkg::RAW_ALT2_LOW]; // RL19
      // Alternates 3 to 11, upper and lower, fold into one flag
      cond_d[qss_pkg::ACP_HIGHER_BIT] =
         |raw_fail[qss_pkg::RAW_HIGHER_MSB:qss_pkg::RAW_HIGHER_LSB]; // RL20
      cond_d[qss_pkg::ACP_GAP_CUM_BIT] = raw_fail[qss_pkg::RAW_GAP_CUM]; // RL21
      cond_d[qss_pkg::ACP_GAP_BIT] = raw_fail[qss_pkg::RAW_GAP]; // RL22
   end

   // Condition view follows the raw flags one cycle later
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_q <= qss_pkg::REG_RESET;
      end else if (ce) begin
         cond_q <= cond_d; // RL16
      end
   end

   // Event view latches rising conditions until read
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_q <= qss_pkg::REG_RESET;
      end else if (ce) begin
         evt_q <= qss_pkg::qss_event_next(evt_q, cond_d, cond_q, evt_clr); // RL16
      end
   end

endmodule // qss_acp_channel
`default_nettype wire

// >>> qss_summary_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks for the summary bank
module qss_summary_properties #(
   parameter int NUM_CHAN = 4,
   parameter int LEVEL_W = 16,
   parameter int SYNC_DEV_MAX = 16
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [NUM_CHAN-1:0] chan_active,
   input wire logic [NUM_CHAN-1:0] time_error,
   input wire logic [NUM_CHAN-1:0] power_questionable,
   input wire logic temperature_questionable,
   input wire logic [NUM_CHAN-1:0] frequency_fault,
   input wire logic not_aligned_indicator,
   input wire logic transducer_break,
   input wire logic premeas_valid,
   input wire logic signed [LEVEL_W-1:0] premeas_level,
   input wire logic signed [LEVEL_W-1:0] expected_level,
   input wire logic rd_en,
   input wire logic rd_reg,
   input wire logic [15:0] rd_data_q,
   input wire logic rd_valid_q,
   input wire logic [15:0] summary_cond_q,
   input wire logic sync_lost_q
);
   logic [1:0] up_q;
   logic signed [LEVEL_W:0] dev;
   logic over;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Arms the latency checks two edges after reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_q <= 2'h0;
      end else if (!up_q[1]) begin
         up_q <= up_q + 2'h1;
      end
   end
   // Premeasurement deviation beyond the allowed amount
   assign dev = {premeas_level[LEVEL_W-1], premeas_level} -
                {expected_level[LEVEL_W-1], expected_level};
   assign over = (dev < 0) ? (-dev > SYNC_DEV_MAX) : (dev > SYNC_DEV_MAX);
   time_or_a: assert property (up_q[1] && $past(ce) |->
      summary_cond_q[2] == (|$past(time_error & chan_active)))
      else $error("time flag wrong");
   power_or_a: assert property (up_q[1] && $past(ce) |->
      summary_cond_q[3] == (|$past(power_questionable & chan_active)))
      else $error("power flag wrong");
   freq_or_a: assert property (up_q[1] && $past(ce) |->
      summary_cond_q[5] == (|$past(frequency_fault & chan_active)))
      else $error("frequency flag wrong");
   temp_follow_a: assert property (up_q[1] && $past(ce) |->
      summary_cond_q[4] == $past(temperature_questionable)) else $error("temperature flag wrong");
   align_follow_a: assert property (up_q[1] && $past(ce) |->
      summary_cond_q[8] == $past(not_aligned_indicator)) else $error("alignment flag wrong");
   trans_follow_a: assert property (up_q[1] && $past(ce) |->
      summary_cond_q[13] == $past(transducer_break)) else $error("transducer flag wrong");
   sync_eval_a: assert property (up_q[1] && ce && premeas_valid |=>
      sync_lost_q == $past(over)) else $error("sync state wrong");
   sync_bit_a: assert property (up_q[1] && $past(ce) |->
      summary_cond_q[11] == $past(sync_lost_q)) else $error("sync flag wrong");
   read_pulse_a: assert property (up_q[1] && $past(ce) |->
      rd_valid_q == $past(rd_en)) else $error("read answer pulse wrong");
   ce_freeze_a: assert property (up_q[1] && !$past(ce) |->
      $stable(summary_cond_q) && $stable(rd_valid_q)) else $error("state moved without enable");
   unused_zero_a: assert property ((summary_cond_q & 16'hC0C3) == 16'h0000)
      else $error("unused summary bit set");
   acp_unused_a: assert property (rd_valid_q && $past(ce) && $past(rd_reg) |->
      rd_data_q[15:9] == 7'h00) else $error("unused limit bit set");
endmodule // qss_summary_properties
`default_nettype wire

// >>> qss_testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int NC = 4;
   localparam int LW = 16;
   localparam int SD = 16;
   logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, temperature_questionable = 1'b0;
   logic not_aligned_indicator = 1'b0, transducer_break = 1'b0, premeas_valid = 1'b1;
   logic rd_en = 1'b0, rd_reg = 1'b0, rd_event = 1'b0, rd_valid_q, sync_lost_q;
   logic [NC-1:0] chan_active = '1, time_error = '0, power_questionable = '0, frequency_fault = '0;
   logic [NC*4-1:0] limit_violation = '0, margin_violation = '0;
   logic signed [LW-1:0] premeas_level = '0, expected_level = '0;
   logic [NC*qss_pkg::ACP_RAW_W-1:0] acp_raw_fail = '0;
   logic [2:0] sel_chan = 3'h0;
   logic [15:0] rd_data_q, summary_cond_q, ex, exp_q[$], msk_q[$];
   int mismatches = 0, cmp_count = 0, cyc = 0, c, w, seed;
   int bitpos[10] = '{2, 3, 4, 5, 8, 9, 10, 11, 13, 0};
   // Free-running 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   qss_summary #(.NUM_CHAN(NC), .NUM_WIN(4), .LEVEL_W(LW), .SYNC_DEV_MAX(SD)) i_dut (
      .sys_clk, .rst_n, .ce, .chan_active, .time_error, .power_questionable,
      .temperature_questionable, .frequency_fault, .not_aligned_indicator, .limit_violation,
      .margin_violation, .transducer_break, .premeas_valid, .premeas_level, .expected_level,
      .acp_raw_fail, .sel_chan, .rd_en, .rd_reg, .rd_event, .rd_data_q, .rd_valid_q,
      .summary_cond_q, .sync_lost_q);
   // One read per cycle; rd_en stays high so reads can run back to back
   task automatic rd(input logic r, input logic e, input logic [2:0] s, input logic [15:0] x,
                     input logic [15:0] m = 16'hFFFF);
      rd_en = 1'b1;
      rd_reg = r;
      rd_event = e;
      sel_chan = s;
      exp_q.push_back(x);
      msk_q.push_back(m);
      @(negedge sys_clk);
   endtask
   // Drops the read request for n cycles
   task automatic idle(input int n);
      rd_en = 1'b0;
      repeat (n) @(negedge sys_clk);
   endtask
   // Drives the source of one summary flag
   task automatic drive(input int k, input logic v);
      case (k)
         0: time_error[c] = v;
         1: power_questionable[c] = v;
         2: temperature_questionable = v;
         3: frequency_fault[c] = v;
         4: not_aligned_indicator = v;
         5: limit_violation[c*4+w] = v;
         6: margin_violation[c*4+w] = v;
         7: premeas_level = v ? expected_level + LW'(SD + 1) : expected_level;
         8: transducer_break = v;
         default: premeas_level = v ? expected_level - LW'(SD) : expected_level;
      endcase
   endtask
   // Compares one read answer with the oldest note
   task automatic check_word(input logic [15:0] got);
      logic [15:0] x, m;
      cmp_count++;
      if (exp_q.size() == 0) begin
         mismatches++;
         $display("BAD %0t unexpected read answer", $time);
      end else begin
         x = exp_q.pop_front();
         m = msk_q.pop_front();
         if ((got & m) !== (x & m)) begin
            mismatches++;
            $display("BAD %0t read got %h want %h", $time, got, x);
         end
      end
   endtask
   // Prints the counts and the verdict, then ends the run
   task automatic report_and_stop();
      if (exp_q.size() != 0) mismatches++;
      $display("Reads compared %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Compares each read answer with the oldest expectation
   always @(negedge sys_clk) begin
      if (rst_n && rd_valid_q) check_word(rd_data_q);
   end
   // Cuts a hung run short
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         $display("BAD %0t run did not finish", $time);
         report_and_stop();
      end
   end
   // Main sequence
   initial begin
      seed = $urandom(32'hD247);
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      expected_level = LW'($urandom_range(4095));
      premeas_level = expected_level;
      rd(1'b0, 1'b0, 3'h0, 16'h0000);
      rd(1'b0, 1'b1, 3'h0, 16'h0000);
      rd(1'b1, 1'b0, 3'h0, 16'h0000);
      rd(1'b1, 1'b1, 3'h0, 16'h0000);
      idle(2);
      for (int k = 0; k < 10; k++) begin
         c = $urandom_range(NC - 1);
         w = $urandom_range(3);
         ex = (k == 9) ? 16'h0000 : 16'h0001 << bitpos[k];
         drive(k, 1'b1);
         idle(4);
         rd(1'b0, 1'b0, 3'h0, ex);
         rd(1'b0, 1'b1, 3'h0, ex);
         rd(1'b0, 1'b1, 3'h0, 16'h0000);
         if (k inside {1, 3, 5, 6}) begin
            chan_active[c] = 1'b0;
            idle(4);
            rd(1'b0, 1'b0, 3'h0, 16'h0000);
         end
         idle(1);
         drive(k, 1'b0);
         chan_active = '1;
         idle(4);
      end
      for (int r = 0; r < qss_pkg::ACP_RAW_W; r++) begin
         c = $urandom_range(NC - 1);
         acp_raw_fail[c*qss_pkg::ACP_RAW_W+r] = 1'b1;
         ex = 16'h0001 << (r < 6 ? r : (r < 24 ? 6 : r - 17));
         idle(4);
         rd(1'b1, 1'b0, 3'(c), ex);
         rd(1'b1, 1'b1, 3'(c), ex);
         rd(1'b1, 1'b0, 3'((c + 1) % NC), 16'h0000);
         rd(1'b0, 1'b0, 3'h0, 16'h1000);
         idle(1);
         acp_raw_fail = '0;
         idle(3);
      end
      rd(1'b1, 1'b0, 3'(NC), 16'h0000);
      rd(1'b0, 1'b1, 3'h0, 16'h1000);
      idle(2);
      ce = 1'b0;
      rd_en = 1'b1;
      temperature_questionable = 1'b1;
      repeat (3) @(negedge sys_clk);
      ce = 1'b1;
      idle(4);
      rd(1'b0, 1'b0, 3'h0, 16'h0010);
      idle(4);
      report_and_stop();
   end
endmodule // testbench
bind qss_summary qss_summary_properties #(.NUM_CHAN(NUM_CHAN), .LEVEL_W(LEVEL_W),
   .SYNC_DEV_MAX(SYNC_DEV_MAX)) i_chk (.sys_clk, .rst_n, .ce, .chan_active, .time_error,
   .power_questionable, .temperature_questionable, .frequency_fault, .not_aligned_indicator,
   .transducer_break, .premeas_valid, .premeas_level, .expected_level, .rd_en, .rd_reg,
   .rd_data_q, .rd_valid_q, .summary_cond_q, .sync_lost_q);
`default_nettype wire
